// ---- rtl/dcr_reset_nmi.sv ----
// Reset combiner and distributor with control-side NMI unit and its watchdog
// Operation
// R1: Enabled flagged condition raises control NMI and starts the NMI watchdog.
// R2: Watchdog not disabled in time asserts its reset output to resets and master NMI.
// R3: Seven NMI conditions: clock loss, bus, RAM, flash, vector, two self-test errors.
// R4: One flag per source; readable, clear register, force register.
// R5: Low on system reset pin resets master and control subsystems.
// R6: Pin driven low on power-on reset, either master watchdog or master NMI watchdog.
// R7: Board holds system pin low eight clocks after input clock is stable.
// R8: Low on analog pin resets analog side; analog power-on reset drives that pin.
// R9: Master CPU reset by power-on or master system reset; peripherals follow.
// R10: Master system reset is pin, watchdogs, software reset or debugger reset.
// R11: Master software and debugger resets also reach control and analog sides.
// R12: Config register holds control reset bit and analog bus reset bit.
// R13: Master can read whether control system reset is asserted.
// R14: Peripheral soft reset acts only when that peripheral is enabled.
// R15: Cause register records pin, power-on, watchdog 0, watchdog 1, software reset.
// R16: Control CPU reset in turn drives the control system reset.
// R17: Control CPU reset is pin, NMI watchdog, software, debugger, or request bit.
// R18: Software and debugger resets reach control side only when propagation enabled.
// R19: Settings register shows analog bus reset and system pin level.
// R20: Shared reset and analog bus bit and analog pin reset the analog side.
// R21: Shared reset is pin, or gated software or debugger reset.
// R22: External peripheral port is reset only by master system reset.
// R23: Each reset asserts asynchronously, releases through two synchronising stages; periph_reset_o is a clocked register without asynchronous assertion.
`timescale 1ns/100ps
`include "dcr_regs.svh"
module dcr_reset_nmi #(
    parameter int unsigned CNMI_WD_CYCLES = `DCR_CNMI_WD_CYCLES,
    parameter int unsigned NPERIPH        = `DCR_NPERIPH
) (
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic                       wb_ack_o,
    output logic [31:0]                wb_dat_o,
    // Board reset pins
    input  wire logic                  system_reset_pin_i,
    output logic                       system_reset_pin_o,
    output logic                       system_reset_pin_oe_o,
    input  wire logic                  analog_reset_pin_i,
    output logic                       analog_reset_pin_o,
    output logic                       analog_reset_pin_oe_o,
    // Power-on reset circuits
    input  wire logic                  por_i,
    input  wire logic                  analog_por_i,
    // Master-side reset sources
    input  wire logic                  master_wd0_timeout_i,
    input  wire logic                  master_wd1_timeout_i,
    input  wire logic                  master_nmi_wd_timeout_i,
    input  wire logic                  master_software_reset_i,
    input  wire logic                  master_debugger_reset_i,
    // NMI conditions
    input  dcr_pkg::dcr_nmi_src_t      nmi_cond_i,
    // NMI outputs
    output logic                       control_cpu_nmi_irq_o,
    output logic                       control_nmi_wd_reset_out_o,
    // Distributed resets
    output dcr_pkg::dcr_resets_t       resets_o,
    output logic [NPERIPH-1:0]         periph_reset_o
);

    localparam logic [31:0] WD_LAST  = 32'(CNMI_WD_CYCLES - 1);
    localparam logic [31:0] RST_LAST = 32'(`DCR_NMI_RST_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                  ack;
    logic [31:0]           rdata;
    logic [31:0]           next_rdata;
    logic [6:0]            nmi_flags;
    logic [6:0]            nmi_en;
    logic                  nmi_irq;
    dcr_pkg::dcr_wd_state_t wd_state;
    logic [31:0]           wd_cnt;
    logic                  wd_expired;
    logic                  nmi_wd_rst;
    logic [2:0]            rst_cfg;
    logic [NPERIPH-1:0]    periph_srst;
    logic [NPERIPH-1:0]    periph_en;
    logic [NPERIPH-1:0]    periph_rst;
    logic [4:0]            cause;
    logic [1:0]            pin_meta;
    logic                  pin_level;
    logic [1:0]            por_meta;
    logic                  por_sync;
    logic [1:0]            apor_meta;
    logic                  apor_sync;
    logic [2:0]            sys_drive;
    logic                  ana_drive;
    logic                  r_mcpu;
    logic                  r_msys;
    logic                  r_ccpu;
    logic                  r_csys;
    logic                  r_shared;
    logic                  r_analog;
    logic                  r_eport;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone decode

    wire        bus_req   = wb_cyc_i & wb_stb_i;
    wire        bus_wr    = bus_req & wb_we_i & ack & wb_sel_i[0];
    wire [31:0] wdat      = wb_dat_i;
    wire        wr_clear  = bus_wr & (wb_adr_i == `DCR_OFS_NMI_CLEAR);
    wire        wr_force  = bus_wr & (wb_adr_i == `DCR_OFS_NMI_FORCE);
    wire        wr_enable = bus_wr & (wb_adr_i == `DCR_OFS_NMI_ENABLE);
    wire        wr_wdctl  = bus_wr & (wb_adr_i == `DCR_OFS_NMI_WD_CTRL);
    wire        wr_cfg    = bus_wr & (wb_adr_i == `DCR_OFS_CTRL_RST_CFG);
    wire        wr_srst   = bus_wr & (wb_adr_i == `DCR_OFS_PERIPH_SRST);
    wire        wr_dcen   = bus_wr & (wb_adr_i == `DCR_OFS_DEV_CFG_EN);
    wire        wr_cause  = bus_wr & (wb_adr_i == `DCR_OFS_RST_CAUSE);
    wire        wd_dis_wr = wr_wdctl & wdat[`DCR_WD_DISABLE];

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ack <= bus_req & ~ack;
            if (bus_req & ~ack) begin
                rdata <= next_rdata;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        case (wb_adr_i)
            `DCR_OFS_NMI_FLAGS:    next_rdata[6:0] = nmi_flags; // R4
            `DCR_OFS_NMI_ENABLE:   next_rdata[6:0] = nmi_en;
            `DCR_OFS_NMI_WD_CTRL: begin
                next_rdata[`DCR_WD_RUNNING] = (wd_state == dcr_pkg::DCR_WD_COUNT);
                next_rdata[`DCR_WD_EXPIRED] = wd_expired;
            end
            `DCR_OFS_CTRL_RST_CFG: next_rdata[2:0] = rst_cfg;
            `DCR_OFS_CTRL_RST_STS: next_rdata[`DCR_STS_CTRL_RST] = r_csys; // R13
            `DCR_OFS_PERIPH_SRST:  next_rdata[NPERIPH-1:0] = periph_srst;
            `DCR_OFS_DEV_CFG_EN:   next_rdata[NPERIPH-1:0] = periph_en;
            `DCR_OFS_RST_CAUSE:    next_rdata[4:0] = cause; // R15
            `DCR_OFS_DEV_SETTINGS: begin
                next_rdata[`DCR_SET_ABUS_RST]  = rst_cfg[`DCR_CFG_ABUS_RST]; // R19
                next_rdata[`DCR_SET_PIN_LEVEL] = pin_level; // R19
            end
            default:               next_rdata = 32'h0;
        endcase
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Control-side NMI flags

    wire [6:0] cond_vec   = nmi_cond_i; // R3
    wire [6:0] clr_mask   = wr_clear ? wdat[6:0] : 7'h0;
    wire [6:0] frc_mask   = wr_force ? wdat[6:0] : 7'h0;
    wire [6:0] next_flags = (nmi_flags & ~clr_mask) | frc_mask | cond_vec; // R4
    wire [6:0] next_en    = wr_enable ? wdat[6:0] : nmi_en;
    wire       next_irq   = |(next_flags & next_en); // R1
    wire       nmi_start  = next_irq & ~nmi_irq;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            nmi_flags <= 7'h0;
            nmi_en    <= `DCR_NMI_EN_RST;
            nmi_irq   <= 1'b0;
        end else begin
            nmi_flags <= next_flags;
            nmi_en    <= next_en;
            nmi_irq   <= next_irq;
        end
    end

    assign control_cpu_nmi_irq_o = nmi_irq;

    flag_clear_a: assert property (wr_clear && wdat[0] && !cond_vec[0] |=> !nmi_flags[0]) // R4
        else $error("flag not cleared");
    flag_force_a: assert property (wr_force && wdat[4] |=> // R4
        nmi_flags[4] && (nmi_irq || !nmi_en[4]))
        else $error("flag not forced");

    ////////////////////////////////////////////////////////////////////////////////
    // Control-side NMI watchdog

    dcr_pkg::dcr_wd_state_t next_wd_state;
    logic [31:0]            next_wd_cnt;
    always_comb begin
        next_wd_state = wd_state;
        next_wd_cnt   = wd_cnt;
        case (wd_state)
            dcr_pkg::DCR_WD_IDLE: begin
                if (nmi_start) begin
                    next_wd_state = dcr_pkg::DCR_WD_COUNT; // R1
                    next_wd_cnt   = 32'h0;
                end
            end
            dcr_pkg::DCR_WD_COUNT: begin
                if (nmi_start) begin
                    next_wd_cnt = 32'h0;
                end else if (wd_dis_wr) begin
                    next_wd_state = dcr_pkg::DCR_WD_IDLE;
                end else if (wd_cnt == WD_LAST) begin
                    next_wd_state = dcr_pkg::DCR_WD_RESET; // R2
                    next_wd_cnt   = 32'h0;
                end else begin
                    next_wd_cnt = wd_cnt + 32'h1;
                end
            end
            dcr_pkg::DCR_WD_RESET: begin
                if (wd_cnt == RST_LAST) begin
                    next_wd_state = dcr_pkg::DCR_WD_IDLE;
                end else begin
                    next_wd_cnt = wd_cnt + 32'h1;
                end
            end
            default: next_wd_state = dcr_pkg::DCR_WD_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wd_state   <= dcr_pkg::DCR_WD_IDLE;
            wd_cnt     <= 32'h0;
            wd_expired <= 1'b0;
            nmi_wd_rst <= 1'b0;
        end else begin
            wd_state   <= next_wd_state;
            wd_cnt     <= next_wd_cnt;
            wd_expired <= (next_wd_state == dcr_pkg::DCR_WD_RESET) | (wd_expired & ~wd_dis_wr);
            nmi_wd_rst <= (next_wd_state == dcr_pkg::DCR_WD_RESET); // R2
        end
    end

    assign control_nmi_wd_reset_out_o = nmi_wd_rst;

    sequence wd_expiry_s;
        wd_state == dcr_pkg::DCR_WD_COUNT && wd_cnt == WD_LAST && !wd_dis_wr && !nmi_start;
    endsequence
    sequence rst_pulse_s;
        nmi_wd_rst[*8] ##1 !nmi_wd_rst;
    endsequence
    wd_expire_a: assert property (wd_expiry_s |=> rst_pulse_s) // R2
        else $error("watchdog reset pulse wrong");
    nmi_start_a: assert property ($rose(nmi_irq) && $past(wd_state) != dcr_pkg::DCR_WD_RESET // R1
        |-> wd_state == dcr_pkg::DCR_WD_COUNT && wd_cnt == 32'h0)
        else $error("watchdog did not start");
    nmi_raise_a: assert property ($rose(|(nmi_flags & nmi_en)) |-> nmi_irq) // R1
        else $error("nmi not raised");
    wd_stop_a: assert property (wd_state == dcr_pkg::DCR_WD_COUNT && wd_dis_wr && !nmi_start // R2
        |=> wd_state == dcr_pkg::DCR_WD_IDLE ##1 !nmi_wd_rst)
        else $error("watchdog not stopped");

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers

    wire [4:0] cause_set = {master_software_reset_i, master_wd1_timeout_i,
                            master_wd0_timeout_i, por_sync, ~pin_level & ~|sys_drive};

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rst_cfg     <= `DCR_CFG_RST;
            periph_srst <= '0;
            periph_en   <= '0;
            cause       <= `DCR_CAUSE_RST;
        end else begin
            if (wr_cfg) begin
                rst_cfg <= wdat[2:0]; // R12
            end
            if (wr_srst) begin
                periph_srst <= wdat[NPERIPH-1:0];
            end
            if (wr_dcen) begin
                periph_en <= wdat[NPERIPH-1:0];
            end
            cause <= (cause & ~(wr_cause ? wdat[4:0] : 5'h0)) | cause_set; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin and power-on synchronisers, pin drivers

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_meta  <= 2'h3;
            por_meta  <= 2'h0;
            apor_meta <= 2'h0;
            sys_drive <= 3'h0;
            ana_drive <= 1'b0;
        end else begin
            pin_meta  <= {pin_meta[0], system_reset_pin_i};
            por_meta  <= {por_meta[0], por_i};
            apor_meta <= {apor_meta[0], analog_por_i};
            sys_drive <= {sys_drive[1:0], por_sync | master_wd0_timeout_i | master_wd1_timeout_i
                          | master_nmi_wd_timeout_i}; // R6
            ana_drive <= apor_sync; // R8
        end
    end

    assign pin_level             = pin_meta[1];
    assign por_sync              = por_meta[1];
    assign apor_sync             = apor_meta[1];
    assign system_reset_pin_o    = 1'b0;
    assign system_reset_pin_oe_o = sys_drive[0];
    assign analog_reset_pin_o    = 1'b0;
    assign analog_reset_pin_oe_o = ana_drive;

    pin_drive_a: assert property (master_wd0_timeout_i || master_nmi_wd_timeout_i // R6
        |=> system_reset_pin_oe_o && !system_reset_pin_o)
        else $error("system pin not driven low");

    ////////////////////////////////////////////////////////////////////////////////
    // Reset combining

    wire pin_low   = ~system_reset_pin_i; // R5
    wire mwd       = master_wd0_timeout_i | master_wd1_timeout_i | master_nmi_wd_timeout_i;
    wire sw_dbg    = master_software_reset_i | master_debugger_reset_i; // R11
    wire gated     = sw_dbg & rst_cfg[`DCR_CFG_PROPAGATE]; // R18
    wire src_msys  = rst_i | pin_low | mwd | sw_dbg; // R10
    wire src_mcpu  = src_msys | por_i; // R9
    wire src_ccpu  = rst_i | pin_low | nmi_wd_rst | gated | rst_cfg[`DCR_CFG_CTRL_REQ]; // R17
    wire src_csys  = rst_i | r_ccpu; // R16
    wire src_share = rst_i | pin_low | gated; // R21
    wire src_ana   = r_shared | rst_cfg[`DCR_CFG_ABUS_RST] | ~analog_reset_pin_i; // R20

    dcr_rst_sync u_mcpu  (.clk_i(mclk_i), .src_i(src_mcpu),  .rst_o(r_mcpu)); // R23
    dcr_rst_sync u_msys  (.clk_i(mclk_i), .src_i(src_msys),  .rst_o(r_msys));
    dcr_rst_sync u_ccpu  (.clk_i(mclk_i), .src_i(src_ccpu),  .rst_o(r_ccpu));
    dcr_rst_sync u_csys  (.clk_i(mclk_i), .src_i(src_csys),  .rst_o(r_csys));
    dcr_rst_sync u_share (.clk_i(mclk_i), .src_i(src_share), .rst_o(r_shared));
    dcr_rst_sync u_ana   (.clk_i(mclk_i), .src_i(src_ana),   .rst_o(r_analog)); // R8
    dcr_rst_sync u_eport (.clk_i(mclk_i), .src_i(src_msys),  .rst_o(r_eport)); // R22

    // Peripheral resets follow master system reset or an enabled soft-reset bit
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            periph_rst <= '1;
        end else begin
            periph_rst <= {NPERIPH{r_msys}} | (periph_srst & periph_en); // R14
        end
    end

    assign periph_reset_o = periph_rst;
    assign resets_o = '{external_peripheral_port: r_eport,
                        shared_analog_reset:      r_shared,
                        analog_subsystem:         r_analog,
                        control_system_reset:     r_csys,
                        control_cpu_reset_in:     r_ccpu,
                        master_system_reset:      r_msys,
                        master_cpu:               r_mcpu};

    ctrl_req_a: assert property (rst_cfg[`DCR_CFG_CTRL_REQ] |-> ##[0:2] resets_o.control_cpu_reset_in) // R17
        else $error("control reset request ignored");
    share_gate_a: assert property (sw_dbg && rst_cfg[`DCR_CFG_PROPAGATE] // R21
        |-> ##[0:2] resets_o.shared_analog_reset && resets_o.control_cpu_reset_in)
        else $error("gated software reset lost");
    periph_en_a: assert property (!r_msys && periph_srst[NPERIPH-1] && !periph_en[NPERIPH-1] // R14
        |=> !periph_rst[NPERIPH-1])
        else $error("disabled peripheral reset");

endmodule : dcr_reset_nmi

// ---- rtl/dcr_regs.svh ----
// Register offsets, field positions, reset values and counts of the reset and NMI block
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

// Byte offsets on the register bus
`define DCR_OFS_NMI_FLAGS    8'h00
`define DCR_OFS_NMI_CLEAR    8'h04
`define DCR_OFS_NMI_FORCE    8'h08
`define DCR_OFS_NMI_ENABLE   8'h0c
`define DCR_OFS_NMI_WD_CTRL  8'h10
`define DCR_OFS_CTRL_RST_CFG 8'h14
`define DCR_OFS_CTRL_RST_STS 8'h18
`define DCR_OFS_PERIPH_SRST  8'h1c
`define DCR_OFS_DEV_CFG_EN   8'h20
`define DCR_OFS_RST_CAUSE    8'h24
`define DCR_OFS_DEV_SETTINGS 8'h28

// Field positions
`define DCR_CFG_CTRL_REQ     0
`define DCR_CFG_ABUS_RST     1
`define DCR_CFG_PROPAGATE    2
`define DCR_WD_DISABLE       0
`define DCR_WD_RUNNING       0
`define DCR_WD_EXPIRED       1
`define DCR_STS_CTRL_RST     0
`define DCR_SET_ABUS_RST     0
`define DCR_SET_PIN_LEVEL    1
`define DCR_CAUSE_EXT        0
`define DCR_CAUSE_POR        1
`define DCR_CAUSE_WD0        2
`define DCR_CAUSE_WD1        3
`define DCR_CAUSE_SW         4

// Reset values
`define DCR_NMI_EN_RST       7'h7f
`define DCR_CFG_RST          3'h0
`define DCR_CAUSE_RST        5'h02

// Counts
`define DCR_NMI_RST_CYC      8
`define DCR_CNMI_WD_CYCLES   65536
`define DCR_NPERIPH          8

`endif

// ---- rtl/dcr_pkg.sv ----
// Types shared by the reset and NMI block
package dcr_pkg;

    typedef struct packed {
        logic master_selftest_error;
        logic control_selftest_error;
        logic vector_fetch_error;
        logic flash_uncorrectable_error;
        logic ram_uncorrectable_error;
        logic analog_bus_error;
        logic clock_loss_flag;
    } dcr_nmi_src_t;

    typedef struct packed {
        logic external_peripheral_port;
        logic shared_analog_reset;
        logic analog_subsystem;
        logic control_system_reset;
        logic control_cpu_reset_in;
        logic master_system_reset;
        logic master_cpu;
    } dcr_resets_t;

    typedef enum logic [1:0] {
        DCR_WD_IDLE,
        DCR_WD_COUNT,
        DCR_WD_RESET
    } dcr_wd_state_t;

endpackage : dcr_pkg

// ---- rtl/dcr_rst_sync.sv ----
// Reset stretcher: asynchronous assertion, two-stage synchronous release
`timescale 1ns/100ps
module dcr_rst_sync (
    // Clock of the reset domain
    input  wire logic clk_i,
    // Active-high asynchronous source
    input  wire logic src_i,
    // Synchronised reset
    output logic      rst_o
);

    logic [1:0] stage;

    always_ff @(posedge clk_i or posedge src_i) begin
        if (src_i) begin
            stage <= 2'h3;
        end else begin
            stage <= {stage[0], 1'b0};
        end
    end

    assign rst_o = stage[1];

endmodule : dcr_rst_sync

// ---- verif/dcr_board_sup.sv ----
// Board reset supervisor model with pulled-up reset pins
`timescale 1ns/100ps
module dcr_board_sup (
    // Clock and board request
    input  wire logic mclk_i,
    input  wire logic ext_rst_i,
    // Chip pull-down enables
    input  wire logic sys_oe_i,
    input  wire logic ana_oe_i,
    // Resolved pin levels
    output logic      sys_pin_o,
    output logic      ana_pin_o
);
    logic [3:0] hold = 4'h0;
    always_ff @(posedge mclk_i) begin
        if (hold != 4'h8) hold <= hold + 4'h1;
    end
    // Pull-ups win only when nobody pulls low
    assign sys_pin_o = !(sys_oe_i || ext_rst_i || hold != 4'h8);
    assign ana_pin_o = !(ana_oe_i || ext_rst_i);
endmodule : dcr_board_sup

// ---- verif/dcr_reset_nmi_tb_top.sv ----
// Self-checking bench of the reset and NMI block
`timescale 1ns/100ps
`include "dcr_regs.svh"
module dcr_reset_nmi_tb_top;
    logic mclk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ext = 1'b0;
    logic por = 1'b1, apor = 1'b0, swr = 1'b0, dbg = 1'b0, ack, irq, wdo, soe, aoe, spin, apin;
    logic [2:0] mwd = 3'h0;
    logic [7:0] adr = 8'h00, prst;
    logic [31:0] wdat = 32'h0, rdat, q;
    dcr_pkg::dcr_nmi_src_t cond = '0;
    dcr_pkg::dcr_resets_t rs;
    int num_errors = 0, samples_checked = 0, n, k;
    always #5 mclk_i = ~mclk_i;
    dcr_reset_nmi #(.CNMI_WD_CYCLES(16), .NPERIPH(8)) dut_u (
        .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .system_reset_pin_i(spin), .system_reset_pin_o(), .system_reset_pin_oe_o(soe),
        .analog_reset_pin_i(apin), .analog_reset_pin_o(), .analog_reset_pin_oe_o(aoe),
        .por_i(por), .analog_por_i(apor), .master_wd0_timeout_i(mwd[0]),
        .master_wd1_timeout_i(mwd[1]), .master_nmi_wd_timeout_i(mwd[2]),
        .master_software_reset_i(swr), .master_debugger_reset_i(dbg), .nmi_cond_i(cond),
        .control_cpu_nmi_irq_o(irq), .control_nmi_wd_reset_out_o(wdo), .resets_o(rs),
        .periph_reset_o(prst));
    dcr_board_sup sup_u (.mclk_i(mclk_i), .ext_rst_i(ext), .sys_oe_i(soe), .ana_oe_i(aoe),
        .sys_pin_o(spin), .ana_pin_o(apin));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic ed(input int c);
        repeat (c) @(posedge mclk_i);
    endtask : ed
    // Classic single cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        @(posedge mclk_i);
        while (ack !== 1'b1) @(posedge mclk_i);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge mclk_i);
    endtask : bus
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        bus(0, `DCR_OFS_NMI_ENABLE, 0); chk(q, 32'h7f);
        bus(0, `DCR_OFS_RST_CAUSE, 0); chk(q, 32'h02);
        bus(0, `DCR_OFS_CTRL_RST_CFG, 0); chk(q, 32'h0);
        bus(1, 8'hf0, 32'hff); bus(0, 8'hf0, 0); chk(q, 32'h0);
        bus(0, `DCR_OFS_NMI_FLAGS, 0); chk(q, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_cfg;
        bus(1, `DCR_OFS_CTRL_RST_CFG, 1); ed(1);
        chk(rs.control_cpu_reset_in, 1);
        chk(rs.control_system_reset, 1);
        bus(0, `DCR_OFS_CTRL_RST_STS, 0); chk(q[0], 1);
        bus(1, `DCR_OFS_CTRL_RST_CFG, 2); ed(6);
        chk(rs.control_cpu_reset_in, 0);
        chk(rs.analog_subsystem, 1);
        bus(0, `DCR_OFS_DEV_SETTINGS, 0); chk(q[1:0], 2'b11);
        bus(1, `DCR_OFS_CTRL_RST_CFG, 0); ed(6);
        bus(0, `DCR_OFS_CTRL_RST_STS, 0); chk(q[0], 0);
        chk(rs.analog_subsystem, 0);
        $display("test cfg done");
    endtask : t_cfg
    task automatic t_periph;
        bus(1, `DCR_OFS_DEV_CFG_EN, 32'h0f); bus(1, `DCR_OFS_PERIPH_SRST, 32'hff); ed(2);
        chk(prst, 8'h0f);
        bus(1, `DCR_OFS_PERIPH_SRST, 0); ed(2); chk(prst, 8'h00);
        $display("test periph done");
    endtask : t_periph
    task automatic t_nmi;
        for (int i = 0; i < 7; i++) begin
            cond <= dcr_pkg::dcr_nmi_src_t'(7'(1 << i)); ed(1);
            cond <= '0; ed(2);
            chk(irq, 1);
            bus(0, `DCR_OFS_NMI_FLAGS, 0); chk(q, 32'(1 << i));
            bus(1, `DCR_OFS_NMI_CLEAR, 32'(1 << i)); bus(1, `DCR_OFS_NMI_WD_CTRL, 1);
            bus(0, `DCR_OFS_NMI_FLAGS, 0); chk(q, 0);
        end
        // Masked forced flag, then unmask and let the watchdog expire
        bus(1, `DCR_OFS_NMI_ENABLE, 0); bus(1, `DCR_OFS_NMI_FORCE, 32'h10); ed(2);
        chk(irq, 0);
        bus(0, `DCR_OFS_NMI_FLAGS, 0); chk(q, 32'h10);
        bus(1, `DCR_OFS_NMI_ENABLE, 32'h7f); ed(2); chk(irq, 1);
        n = 0;
        while (wdo !== 1'b1 && n < 40) begin
            ed(1);
            n++;
        end
        chk(n >= 12 && n <= 18, 1);
        chk(rs.control_cpu_reset_in, 1);
        k = 0;
        while (wdo === 1'b1 && k < 20) begin
            ed(1);
            k++;
        end
        chk(k, 8);
        bus(1, `DCR_OFS_NMI_CLEAR, 32'h7f); bus(1, `DCR_OFS_NMI_WD_CTRL, 1);
        $display("test nmi done");
    endtask : t_nmi
    task automatic t_srcs;
        swr <= 1'b1; ed(2);
        chk(rs.master_system_reset, 1);
        chk(rs.master_cpu, 1);
        chk(rs.external_peripheral_port, 1);
        chk(rs.control_cpu_reset_in, 0);
        chk(rs.shared_analog_reset, 0);
        swr <= 1'b0; ed(6);
        bus(1, `DCR_OFS_CTRL_RST_CFG, 4); dbg <= 1'b1; ed(2);
        chk(rs.control_cpu_reset_in, 1);
        chk(rs.shared_analog_reset, 1);
        chk(rs.analog_subsystem, 1);
        dbg <= 1'b0; ed(6); bus(1, `DCR_OFS_CTRL_RST_CFG, 0);
        for (int i = 0; i < 3; i++) begin
            mwd <= 3'(1 << i); ed(3);
            chk(soe, 1);
            chk(rs.master_system_reset, 1);
            mwd <= 3'h0; ed(8);
            bus(0, `DCR_OFS_RST_CAUSE, 0);
            if (i < 2) chk(q[`DCR_CAUSE_WD0 + i], 1);
            chk(q[`DCR_CAUSE_EXT], 0);
            bus(1, `DCR_OFS_RST_CAUSE, 32'h1f);
        end
        $display("test sources done");
    endtask : t_srcs
    task automatic t_pins;
        ext <= 1'b1; ed(4);
        chk(rs.master_system_reset, 1);
        chk(rs.control_cpu_reset_in, 1);
        chk(rs.analog_subsystem, 1);
        ext <= 1'b0; ed(8);
        bus(0, `DCR_OFS_RST_CAUSE, 0); chk(q[`DCR_CAUSE_EXT], 1);
        apor <= 1'b1; ed(4);
        chk(aoe, 1);
        chk(rs.analog_subsystem, 1);
        apor <= 1'b0; ed(8); chk(rs.analog_subsystem, 0);
        por <= 1'b1; ed(4);
        chk(soe, 1);
        chk(rs.master_cpu, 1);
        por <= 1'b0; ed(8); chk(rs.master_cpu, 0);
        $display("test pins done");
    endtask : t_pins
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ed(12);
        rst_i <= 1'b0;
        por <= 1'b0;
        ed(1);
        t_regs();
        t_cfg();
        t_periph();
        t_nmi();
        t_srcs();
        t_pins();
        complete_run();
    end
    initial begin
        #200us;
        num_errors++;
        complete_run();
    end
endmodule : dcr_reset_nmi_tb_top
